/* common/tws_pkg.sv */
// constants, types and state codes shared by the three-wire eeprom design
`default_nettype none
package tws_pkg;
  // system clock rate and the self-timed programming time
  localparam int CLK_MHZ            = 125;
  localparam int PROGRAM_CYCLE_TIME = 5;        // ms, longest programming time
  localparam int PROG_CYCLES        = PROGRAM_CYCLE_TIME * 1000 * CLK_MHZ;

  // array geometry: 512 bytes, or 256 words built from byte pairs
  localparam int MEM_BYTES = 512;
  localparam int BYTE_W    = 8;
  localparam int ADDR_W    = 9;
  localparam int WORD_W    = 16;
  localparam int CNT_W     = 5;
  localparam int FIFO_DEPTH = 8;

  // frame field lengths: opcode plus address, and data, in bits
  localparam logic [4:0] HDR_BITS_BYTE  = 5'h0B;
  localparam logic [4:0] HDR_BITS_WORD  = 5'h0A;
  localparam logic [4:0] DATA_BITS_BYTE = 5'h08;
  localparam logic [4:0] DATA_BITS_WORD = 5'h10;

  // opcodes and the sub-commands carried in the top address bits
  localparam logic [1:0] OP_EXT     = 2'h0;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] SUB_DIS    = 2'h0;
  localparam logic [1:0] SUB_WRALL  = 2'h1;
  localparam logic [1:0] SUB_ERALL  = 2'h2;
  localparam logic [1:0] SUB_EN     = 2'h3;

  // array variants: pin-selected, byte-only, word-only
  localparam logic [1:0] VAR_SELECT = 2'h0;
  localparam logic [1:0] VAR_BYTE   = 2'h1;
  localparam logic [1:0] VAR_WORD   = 2'h2;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [8:0] LAST_BYTE   = 9'h1FF;
  // synchroniser reset: {select, clock, data, organization}, organization pulled up
  localparam logic [3:0] PIN_RESET   = 4'h1;

  typedef enum logic [1:0] {
    PK_WRITE = 2'h0,
    PK_ERASE = 2'h1,
    PK_WRALL = 2'h2,
    PK_ERALL = 2'h3
  } tws_kind_t;

  // one queued programming job
  typedef struct packed {
    tws_kind_t   kind;
    logic        wide;
    logic [8:0]  addr;
    logic [15:0] data;
  } tws_prog_cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_DATA = 5'b00100,
    ST_READ = 5'b01000,
    ST_STAT = 5'b10000
  } tws_state_t;
endpackage
`default_nettype wire

/* rtl/tws_eeprom.sv */
// three-wire serial eeprom: job fifo and the frame decoder with its array
`timescale 1ns/1ns
`default_nettype none

module tws_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  // honest flags from the fill count
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = store[rd_ptr];

  // pointer wrap, shared by both ends
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // pointers and count
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_i) begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage needs no reset, only valid slots are read
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && push) store[wr_ptr] <= in_data_i;
  end
endmodule // tws_fifo

module tws_eeprom #(
  parameter logic [1:0] VARIANT     = tws_pkg::VAR_SELECT,
  parameter int         PROG_CYCLES = tws_pkg::PROG_CYCLES,
  parameter int         FIFO_DEPTH  = tws_pkg::FIFO_DEPTH
) (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  input  wire logic chip_select_i,
  input  wire logic serial_clock_in_i,
  input  wire logic serial_data_in_i,
  input  wire logic organization_select_i,
  output logic      serial_data_out_o,
  output logic      serial_data_out_oe_o
);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  // pin synchronisers, second stage feeds all logic
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic       sk_prev;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pin_s1  <= tws_pkg::PIN_RESET;
      pin_s2  <= tws_pkg::PIN_RESET;
      sk_prev <= 1'b0;
    end else if (ce_i) begin
      pin_s1  <= {chip_select_i, serial_clock_in_i, serial_data_in_i, organization_select_i};
      pin_s2  <= pin_s1;
      sk_prev <= pin_s2[2];
    end
  end

  wire cs_q    = pin_s2[3];
  wire sk_q    = pin_s2[2];
  wire di_q    = pin_s2[1];
  wire org_q   = pin_s2[0];
  wire sk_rise = sk_q & ~sk_prev;
  wire sk_fall = ~sk_q & sk_prev;

  // organization: fixed variants never look at the pin
  wire wide = (VARIANT == tws_pkg::VAR_WORD) |
              ((VARIANT == tws_pkg::VAR_SELECT) & org_q);

  // decoder state
  tws_pkg::tws_state_t state;
  tws_pkg::tws_state_t next_state;
  logic [4:0]   cnt;
  logic [4:0]   next_cnt;
  logic [9:0]   hdr_sh;
  logic [9:0]   next_hdr_sh;
  logic [15:0]  dat_sh;
  logic [15:0]  next_dat_sh;
  logic         write_en;
  logic         next_write_en;
  logic [1:0]   kind_q;
  logic [1:0]   next_kind_q;
  logic [8:0]   addr_q;
  logic [8:0]   next_addr_q;
  logic [15:0]  rd_sh;
  logic [15:0]  next_rd_sh;
  logic [4:0]   rd_cnt;
  logic [4:0]   next_rd_cnt;
  logic [8:0]   rd_addr;
  logic [8:0]   next_rd_addr;
  logic         do_q;
  logic         next_do_q;
  logic         oe_q;
  logic         next_oe_q;

  // engine and array
  logic [7:0]             mem [tws_pkg::MEM_BYTES];
  logic                   eng_active;
  logic                   sweeping;
  logic [TW-1:0]          timer;
  logic [8:0]             idx;
  logic [8:0]             idx_end;
  tws_pkg::tws_prog_cmd_t eng_cmd;

  // fifo hookup
  tws_pkg::tws_prog_cmd_t push_cmd;
  tws_pkg::tws_prog_cmd_t pop_cmd;
  logic                   push_valid;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  wire                    pop_take = fifo_out_valid & ~eng_active;

  // programming in flight: queued, running, or no room for another job
  wire busy = eng_active | fifo_out_valid | ~fifo_in_ready;

  // header fields once the last address bit arrives, msb first
  wire [10:0] full_hdr  = {hdr_sh, di_q};
  wire [4:0]  hdr_bits  = wide ? tws_pkg::HDR_BITS_WORD : tws_pkg::HDR_BITS_BYTE;
  wire [4:0]  data_bits = wide ? tws_pkg::DATA_BITS_WORD : tws_pkg::DATA_BITS_BYTE;
  wire        hdr_done  = sk_rise & (cnt == hdr_bits - 5'h01);
  wire        data_done = sk_rise & (cnt == data_bits - 5'h01);
  wire [1:0]  new_op    = wide ? full_hdr[9:8] : full_hdr[10:9];
  wire [8:0]  new_addr  = wide ? {1'b0, full_hdr[7:0]} : full_hdr[8:0];
  wire [1:0]  new_sub   = wide ? full_hdr[7:6] : full_hdr[8:7];
  wire [15:0] data_full = {dat_sh[14:0], di_q};

  // opcode decode
  wire ext_op  = (new_op == tws_pkg::OP_EXT);
  wire do_read = (new_op == tws_pkg::OP_READ);
  wire do_wr   = (new_op == tws_pkg::OP_WRITE);
  wire do_er   = (new_op == tws_pkg::OP_ERASE);
  wire do_write_all_cmd = ext_op & (new_sub == tws_pkg::SUB_WRALL);
  wire do_erase_all_cmd = ext_op & (new_sub == tws_pkg::SUB_ERALL);
  wire do_en   = ext_op & (new_sub == tws_pkg::SUB_EN);
  wire do_dis  = ext_op & (new_sub == tws_pkg::SUB_DIS);
  wire [1:0] hdr_kind = do_er ? tws_pkg::PK_ERASE :
                        do_erase_all_cmd ? tws_pkg::PK_ERALL :
                        do_write_all_cmd ? tws_pkg::PK_WRALL : tws_pkg::PK_WRITE;

  // jobs only queue while writing is enabled
  wire push_nodata = (state == tws_pkg::ST_CMD) & cs_q & hdr_done & (do_er | do_erase_all_cmd);
  wire push_data   = (state == tws_pkg::ST_DATA) & cs_q & data_done;
  assign push_valid = (push_nodata | push_data) & write_en;

  assign push_cmd.kind = push_data ? tws_pkg::tws_kind_t'(kind_q)
                                   : tws_pkg::tws_kind_t'(hdr_kind);
  assign push_cmd.wide = wide;
  assign push_cmd.addr = push_data ? addr_q : new_addr;
  assign push_cmd.data = wide ? data_full : {8'h00, data_full[7:0]};

  // read fetch: first word at the frame address, then autoincrement
  wire [8:0] rd_next  = wide ? {1'b0, rd_addr[7:0] + 8'h01} : rd_addr + 9'h001;
  wire [8:0] rd_src   = (state == tws_pkg::ST_CMD) ? new_addr : rd_next;
  wire [8:0] rd_hi    = wide ? {rd_src[7:0], 1'b0} : rd_src;
  wire [8:0] rd_lo    = {rd_src[7:0], 1'b1};
  wire [15:0] rd_word = wide ? {mem[rd_hi], mem[rd_lo]} : {mem[rd_hi], 8'h00};

  // decoder next state; the clock input only counts outside programming
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_hdr_sh   = hdr_sh;
    next_dat_sh   = dat_sh;
    next_write_en = write_en;
    next_kind_q   = kind_q;
    next_addr_q   = addr_q;
    next_rd_sh    = rd_sh;
    next_rd_cnt   = rd_cnt;
    next_rd_addr  = rd_addr;
    next_do_q     = do_q;
    next_oe_q     = oe_q;
    case (state)
      tws_pkg::ST_IDLE: begin
        next_oe_q = 1'b0;
        if (cs_q && sk_rise && di_q && !busy) begin
          next_state = tws_pkg::ST_CMD;
          next_cnt   = '0;
        end
      end
      tws_pkg::ST_CMD: begin
        if (!cs_q) begin
          next_state = tws_pkg::ST_IDLE;
        end else if (sk_rise) begin
          next_hdr_sh = full_hdr[9:0];
          next_cnt    = cnt + 5'h01;
          if (hdr_done) begin
            next_cnt    = '0;
            next_kind_q = hdr_kind;
            next_addr_q = new_addr;
            if (do_read) begin
              next_state   = tws_pkg::ST_READ;
              next_rd_sh   = rd_word;
              next_rd_cnt  = data_bits;
              next_rd_addr = new_addr;
              next_do_q    = 1'b0;  // dummy zero ahead of data
              next_oe_q    = 1'b1;
            end else if (do_wr || do_write_all_cmd) begin
              next_state = tws_pkg::ST_DATA;
            end else if (do_er || do_erase_all_cmd) begin
              next_state = write_en ? tws_pkg::ST_STAT : tws_pkg::ST_IDLE;
            end else begin
              if (do_en) next_write_en = 1'b1;
              if (do_dis) next_write_en = 1'b0;
              next_state = tws_pkg::ST_IDLE;
            end
          end
        end
      end
      tws_pkg::ST_DATA: begin
        if (!cs_q) begin
          next_state = tws_pkg::ST_IDLE;  // a cut data field programs nothing
        end else if (sk_rise) begin
          next_dat_sh = data_full;
          next_cnt    = cnt + 5'h01;
          if (data_done) begin
            next_state = write_en ? tws_pkg::ST_STAT : tws_pkg::ST_IDLE;
          end
        end
      end
      tws_pkg::ST_READ: begin
        if (!cs_q) begin
          next_state = tws_pkg::ST_IDLE;
          next_oe_q  = 1'b0;
        end else if (sk_fall) begin
          // running past a word continues at the next address
          if (rd_cnt == '0) begin
            next_do_q    = rd_word[15];
            next_rd_sh   = {rd_word[14:0], 1'b0};
            next_rd_cnt  = data_bits - 5'h01;
            next_rd_addr = rd_src;
          end else begin
            next_do_q   = rd_sh[15];
            next_rd_sh  = {rd_sh[14:0], 1'b0};
            next_rd_cnt = rd_cnt - 5'h01;
          end
        end
      end
      tws_pkg::ST_STAT: begin
        next_oe_q = 1'b1;
        next_do_q = ~busy;
        if (!busy && (!cs_q || di_q)) begin
          next_state = tws_pkg::ST_IDLE;
          next_oe_q  = 1'b0;
        end
      end
      default: begin
        next_state = tws_pkg::ST_IDLE;
        next_oe_q  = 1'b0;
      end
    endcase
  end

  // decoder registers; writing comes up disabled
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state    <= tws_pkg::ST_IDLE;
      cnt      <= '0;
      hdr_sh   <= '0;
      dat_sh   <= '0;
      write_en <= 1'b0;
      kind_q   <= '0;
      addr_q   <= '0;
      rd_sh    <= '0;
      rd_cnt   <= '0;
      rd_addr  <= '0;
      do_q     <= 1'b0;
      oe_q     <= 1'b0;
    end else if (ce_i) begin
      state    <= next_state;
      cnt      <= next_cnt;
      hdr_sh   <= next_hdr_sh;
      dat_sh   <= next_dat_sh;
      write_en <= next_write_en;
      kind_q   <= next_kind_q;
      addr_q   <= next_addr_q;
      rd_sh    <= next_rd_sh;
      rd_cnt   <= next_rd_cnt;
      rd_addr  <= next_rd_addr;
      do_q     <= next_do_q;
      oe_q     <= next_oe_q;
    end
  end

  assign serial_data_out_o    = do_q;
  assign serial_data_out_oe_o = oe_q;

  // job queue between frame decoder and programming engine
  tws_fifo #(
    .WIDTH ($bits(tws_pkg::tws_prog_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_job_fifo (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_cmd),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (~eng_active),
    .out_data_o  (pop_cmd)
  );

  // byte span of a job: whole array for the all-forms, one or two bytes otherwise
  wire all_job = (pop_cmd.kind == tws_pkg::PK_WRALL) | (pop_cmd.kind == tws_pkg::PK_ERALL);
  wire [8:0] span_lo = all_job ? '0 :
                       pop_cmd.wide ? {pop_cmd.addr[7:0], 1'b0} : pop_cmd.addr;
  wire [8:0] span_hi = all_job ? tws_pkg::LAST_BYTE :
                       pop_cmd.wide ? {pop_cmd.addr[7:0], 1'b1} : pop_cmd.addr;

  // byte written at idx: erase forms fill ones, word data high byte first
  wire erase_job = (eng_cmd.kind == tws_pkg::PK_ERASE) | (eng_cmd.kind == tws_pkg::PK_ERALL);
  wire [7:0] data_byte = (eng_cmd.wide && !idx[0]) ? eng_cmd.data[15:8] : eng_cmd.data[7:0];
  wire [7:0] wr_byte   = erase_job ? tws_pkg::ERASED_BYTE : data_byte;
  wire       wr_en     = eng_active & sweeping;

  // engine: sweep the span, then hold busy until the timer runs out;
  // the sweep (at most 512 cycles) must be shorter than the timer
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      eng_active <= 1'b0;
      sweeping   <= 1'b0;
      timer      <= '0;
      idx        <= '0;
      idx_end    <= '0;
      eng_cmd    <= '0;
    end else if (ce_i) begin
      if (pop_take) begin
        eng_active <= 1'b1;
        sweeping   <= 1'b1;
        timer      <= TW'(PROG_CYCLES - 1);
        idx        <= span_lo;
        idx_end    <= span_hi;
        eng_cmd    <= pop_cmd;
      end else if (eng_active) begin
        if (sweeping) begin
          sweeping <= (idx != idx_end);
          idx      <= idx + 9'h001;
        end
        if (timer == '0) eng_active <= 1'b0;
        else timer <= timer - TW'(1);
      end
    end
  end

  // array write port, no reset: contents survive a decoder reset
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && wr_en) mem[idx] <= wr_byte;
  end
endmodule // tws_eeprom
`default_nettype wire

/* verification/tws_eeprom_monitor.sv */
// concurrent checks on the ports of the three-wire eeprom top
`timescale 1ns/1ns
`default_nettype none
module tws_eeprom_monitor #(
  parameter int PROG_CYCLES = 600
) (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  input  wire logic chip_select_i,
  input  wire logic serial_clock_in_i,
  input  wire logic serial_data_in_i,
  input  wire logic organization_select_i,
  input  wire logic serial_data_out_o,
  input  wire logic serial_data_out_oe_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  int unsigned low_cnt;
  logic [3:0]  cs_hist;

  // length of the current driven-low stretch; long ones are busy status or runs of zero bits in a read
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      low_cnt <= '0;
      cs_hist <= 4'h0;
    end else if (ce_i) begin
      cs_hist <= {cs_hist[2:0], chip_select_i};
      low_cnt <= (serial_data_out_oe_o && !serial_data_out_o) ? low_cnt + 1 : '0;
    end
  end

  a_reset_quiet: assert property (
    $rose(resetn_i) |-> !serial_data_out_oe_o && !serial_data_out_o)
    else $error("output driven right after reset");
  a_release_cs: assert property (
    $fell(chip_select_i) && serial_data_out_o && serial_data_out_oe_o
    |-> ##[1:6] !serial_data_out_oe_o) else $error("no release after select low");
  a_release_di: assert property (
    chip_select_i && $rose(serial_data_in_i) && serial_data_out_o && serial_data_out_oe_o
    |-> ##[1:6] !serial_data_out_oe_o) else $error("no release after data high");
  a_oe_needs_cs: assert property (
    $rose(serial_data_out_oe_o) |-> $past(chip_select_i, 3))
    else $error("output driven without a selected frame");
  a_first_low: assert property (
    $rose(serial_data_out_oe_o) |-> !serial_data_out_o)
    else $error("first driven bit not low");
  a_busy_holds: assert property (
    low_cnt > 20 && chip_select_i && (&cs_hist) |=> serial_data_out_oe_o)
    else $error("busy status dropped while selected");
  a_prog_bounded: assert property (
    low_cnt <= PROG_CYCLES + 16) else $error("programming took too long");
  a_done_stands: assert property (
    $rose(serial_data_out_o) && serial_data_out_oe_o && $past(low_cnt) > 20
    |-> (serial_data_out_o || !serial_data_out_oe_o) [*4]) else $error("done status lost");

  c_status_done: cover property ($rose(serial_data_out_o) && $past(low_cnt) > 20);
  c_read_bit: cover property ($rose(serial_data_out_oe_o) ##[1:20] $rose(serial_data_out_o));
  c_di_release: cover property (chip_select_i && $fell(serial_data_out_oe_o));
endmodule // tws_eeprom_monitor

bind tws_eeprom tws_eeprom_monitor #(.PROG_CYCLES(PROG_CYCLES)) tws_eeprom_monitor_inst (
  .sys_clk_i            (sys_clk_i),
  .resetn_i             (resetn_i),
  .ce_i                 (ce_i),
  .chip_select_i        (chip_select_i),
  .serial_clock_in_i    (serial_clock_in_i),
  .serial_data_in_i     (serial_data_in_i),
  .organization_select_i(organization_select_i),
  .serial_data_out_o    (serial_data_out_o),
  .serial_data_out_oe_o (serial_data_out_oe_o)
);
`default_nettype wire

/* verification/tws_eeprom_tb.sv */
// self-checking bench for the three-wire eeprom
`timescale 1ns/1ns
`default_nettype none
module tws_eeprom_tb;
  logic sys_clk_i;
  logic resetn_i;
  logic ce_i;
  logic organization_select;
  logic cs;
  logic sk;
  logic di;
  logic out;
  logic oe;
  logic out_w;
  logic oe_w;
  logic use_w;
  int   errors;
  int   n_tests;
  int   cycles;

  tws_eeprom #(.VARIANT(tws_pkg::VAR_SELECT), .PROG_CYCLES(600)) tws_eeprom_inst (
    .sys_clk_i            (sys_clk_i),
    .resetn_i             (resetn_i),
    .ce_i                 (ce_i),
    .chip_select_i        (cs),
    .serial_clock_in_i    (sk),
    .serial_data_in_i     (di),
    .organization_select_i(organization_select),
    .serial_data_out_o    (out),
    .serial_data_out_oe_o (oe)
  );

  // word-only variant shares the pins; its organization input must not matter
  tws_eeprom #(.VARIANT(tws_pkg::VAR_WORD), .PROG_CYCLES(600)) tws_eeprom_fixed_inst (
    .sys_clk_i            (sys_clk_i),
    .resetn_i             (resetn_i),
    .ce_i                 (ce_i),
    .chip_select_i        (cs),
    .serial_clock_in_i    (sk),
    .serial_data_in_i     (di),
    .organization_select_i(organization_select),
    .serial_data_out_o    (out_w),
    .serial_data_out_oe_o (oe_w)
  );

  // a released output reads as the inverse of its last value, never as stale data
  wire  host_in = use_w ? (oe_w ? out_w : ~out_w) : (oe ? out : ~out);

  tws_host tws_host_inst (
    .sys_clk_i        (sys_clk_i),
    .serial_data_out_i(host_in),
    .chip_select_o    (cs),
    .serial_clock_o   (sk),
    .serial_data_o    (di)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hang ends the run through the same report
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("MISMATCH t=%0t run too long", $time);
      print_verdict();
    end
  end

  task automatic wait_done();
    int k;
    k = 0;
    while (host_in !== 1'b1 && k < 800) begin
      @(posedge sys_clk_i);
      k++;
    end
    check({16'h0, host_in}, 17'h1, "status done");
  endtask

  // busy status, optional ignored frame, wait, then release by select or data
  task automatic prog_tail(input logic by_di, input logic poke);
    check({15'h0, oe, out}, 17'h2, "busy status");
    tws_host_inst.close_frame(1'b1, 1'b0);
    if (poke) begin
      tws_host_inst.send({21'h0, 3'b111, 8'h05}, 11);
      tws_host_inst.close_frame(1'b1, 1'b0);
    end
    wait_done();
    tws_host_inst.close_frame(by_di, by_di);
    tws_host_inst.hold(4);
    check({16'h0, oe}, 17'h0, "status released");
    tws_host_inst.close_frame(1'b0, 1'b0);
  endtask

  task automatic read_chk(input logic [31:0] hdr, input int n, input int w,
                          input logic [16:0] exp);
    logic [16:0] v;
    tws_host_inst.send(hdr, n);
    tws_host_inst.recv(v, w);
    check(v, exp, "read data");
    tws_host_inst.close_frame(1'b0, 1'b0);
  endtask

  task automatic locked_frame(input logic [31:0] v, input int n);
    tws_host_inst.send(v, n);
    check({16'h0, oe}, 17'h0, "write refused");
    tws_host_inst.close_frame(1'b0, 1'b0);
  endtask

  // after reset writes are refused; enable, write, ignored erase while busy
  task automatic t_word();
    locked_frame({5'h0, 3'b101, 8'h05, 16'h1234}, 27);
    tws_host_inst.send({21'h0, 3'b100, 8'hC0}, 11);
    tws_host_inst.close_frame(1'b0, 1'b0);
    tws_host_inst.send({5'h0, 3'b101, 8'h05, 16'hA55A}, 27);
    prog_tail(1'b0, 1'b1);
    read_chk({21'h0, 3'b110, 8'h05}, 11, 16, {1'b0, 16'hA55A});
  endtask

  // byte organisation: halves of the word, erase one byte, release by data
  task automatic t_byte();
    organization_select <= 1'b0;
    tws_host_inst.hold(4);
    read_chk({20'h0, 3'b110, 9'h00A}, 12, 8, {9'h0, 8'hA5});
    tws_host_inst.send({20'h0, 3'b111, 9'h00A}, 12);
    prog_tail(1'b1, 1'b0);
    read_chk({20'h0, 3'b110, 9'h00A}, 12, 8, {9'h0, 8'hFF});
    read_chk({20'h0, 3'b110, 9'h00B}, 12, 8, {9'h0, 8'h5A});
  endtask

  // fill, clear, abort mid-frame, then lock again
  task automatic t_all();
    organization_select <= 1'b1;
    tws_host_inst.hold(4);
    tws_host_inst.send({5'h0, 3'b100, 8'h40, 16'h1357}, 27);
    prog_tail(1'b0, 1'b0);
    read_chk({21'h0, 3'b110, 8'hFF}, 11, 16, {1'b0, 16'h1357});
    // pin asks for bytes, yet the word-only part still answers a word frame
    organization_select   <= 1'b0;
    use_w <= 1'b1;
    tws_host_inst.hold(4);
    read_chk({21'h0, 3'b110, 8'h20}, 11, 16, {1'b0, 16'h1357});
    organization_select   <= 1'b1;
    use_w <= 1'b0;
    tws_host_inst.hold(4);
    tws_host_inst.send({21'h0, 3'b100, 8'h80}, 11);
    prog_tail(1'b0, 1'b0);
    tws_host_inst.send({17'h0, 3'b101, 8'h80, 4'h0}, 15);
    tws_host_inst.close_frame(1'b0, 1'b0);
    check({16'h0, oe}, 17'h0, "aborted frame");
    read_chk({21'h0, 3'b110, 8'h80}, 11, 16, {1'b0, 16'hFFFF});
    tws_host_inst.send({21'h0, 3'b100, 8'h00}, 11);
    tws_host_inst.close_frame(1'b0, 1'b0);
    locked_frame({5'h0, 3'b101, 8'h80, 16'h0000}, 27);
    read_chk({21'h0, 3'b110, 8'h80}, 11, 16, {1'b0, 16'hFFFF});
  endtask

  initial begin
    errors   = 0;
    n_tests  = 0;
    cycles   = 0;
    resetn_i = 1'b0;
    ce_i     = 1'b1;
    organization_select      = 1'b1;
    use_w    = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    tws_host_inst.hold(3); // power-up settle, scaled down to the sync pipeline
    t_word();
    t_byte();
    t_all();
    print_verdict();
  end
endmodule // tws_eeprom_tb
`default_nettype wire

/* verification/tws_host.sv */
// host model driving frames on the three-wire link
`timescale 1ns/1ns
`default_nettype none
module tws_host #(
  parameter int HALF = 6
) (
  input  wire logic sys_clk_i,
  input  wire logic serial_data_out_i,
  output logic      chip_select_o,
  output logic      serial_clock_o,
  output logic      serial_data_o
);
  // link clock idles low outside frames
  initial begin
    chip_select_o  = 1'b0;
    serial_clock_o = 1'b0;
    serial_data_o  = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // start bit comes from the caller's word; clock left high after the last bit
  task automatic send(input logic [31:0] v, input int n);
    @(posedge sys_clk_i);
    chip_select_o <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_clock_o <= 1'b0;
      serial_data_o  <= v[i];  // msb first
      hold(HALF);
      serial_clock_o <= 1'b1;  // device samples on the rise
      hold(HALF);
    end
  endtask

  // dummy bit is seen before the first fall, data bits after each fall
  task automatic recv(output logic [16:0] v, input int n);
    v    = '0;
    v[n] = serial_data_out_i;
    for (int i = n - 1; i >= 0; i--) begin
      serial_clock_o <= 1'b0;
      serial_data_o  <= 1'b0;
      hold(HALF);
      v[i] = serial_data_out_i;
      serial_clock_o <= 1'b1;
      hold(HALF);
    end
  endtask

  task automatic close_frame(input logic cs, input logic di);
    serial_clock_o <= 1'b0;
    serial_data_o  <= di;
    chip_select_o  <= cs;
    hold(HALF);
  endtask
endmodule // tws_host
`default_nettype wire
